// ---- verilog/tc_alloc_pkg.sv ----
package tc_alloc_pkg;

    // ------------------------------------------------------------------
    // Sampling rate, rate class and field kinds
    // ------------------------------------------------------------------
    typedef enum logic {FS_12K8, FS_16K} fs_sel_t;
    typedef enum logic {RATE_32K, RATE_64K} rate_class_t;
    typedef enum logic [1:0] {EXC_NONE, EXC_ALG, EXC_GS, EXC_ADA} exc_kind_t;
    typedef enum logic [1:0] {PIT_NONE, PIT_ABS, PIT_DELTA} pit_kind_t;
    typedef enum logic [1:0] {
        GAIN_NONE, GAIN_ALG, GAIN_VQ, GAIN_SQ
    } gain_kind_t;

    // ------------------------------------------------------------------
    // Widths and constants
    // ------------------------------------------------------------------
    localparam int VAR_W = 3;
    localparam int SF_W = 3;
    localparam int LEN_W = 8;
    localparam int POS_W = 8;
    localparam int BITS_W = 4;
    localparam int PFX_W = 4;
    localparam logic [2:0] NUM_VAR_12K8 = 3'h7;
    localparam logic [2:0] NUM_VAR_16K = 3'h5;
    localparam logic [2:0] NUM_SF_12K8 = 3'h4;
    localparam logic [2:0] NUM_SF_16K = 3'h5;
    localparam logic [9:0] PITCH_MIN_12K8 = 10'h022;
    localparam logic [9:0] PITCH_MIN_16K = 10'h02a;
    localparam logic [9:0] PITCH_MAX_TC4 = 10'h0e7;
    localparam logic [3:0] W_ALG_GAIN = 4'h3;
    localparam logic [3:0] W_ALG_GAIN_HI = 4'h6;
    localparam logic [3:0] W_VQ_GAIN = 4'h6;
    localparam logic [3:0] W_SQ_GAIN = 4'hc;
    localparam logic [3:0] W_P5 = 4'h5;
    localparam logic [3:0] W_P6 = 4'h6;
    localparam logic [3:0] W_P7 = 4'h7;
    localparam logic [3:0] W_P8 = 4'h8;
    localparam logic [3:0] W_P9 = 4'h9;
    localparam logic [3:0] W_P10 = 4'ha;
    localparam int LAT_CYCLES = 1;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        fs_sel_t fs;
        rate_class_t rate;
        logic [VAR_W-1:0] variant;
        logic [SF_W-1:0] subframe;
        logic [LEN_W-1:0] sf_len;
        logic [POS_W-1:0] imp_pos;
    } alloc_req_t;

    typedef struct packed {
        exc_kind_t exc;
        pit_kind_t pit;
        logic [BITS_W-1:0] pit_bits;
        logic [9:0] pit_min;
        logic [9:0] pit_max;
        gain_kind_t gain;
        logic [BITS_W-1:0] gain_bits;
        logic [PFX_W-1:0] prefix;
        logic [2:0] prefix_len;
        logic invalid;
    } alloc_ans_t;

endpackage

// ---- verilog/tc_prefix_rom.sv ----
`timescale 1ns/1ps
// Prefix code lookup with registered output
module tc_prefix_rom
    import tc_alloc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Lookup
    input wire fs_sel_t fs,
    input wire logic [VAR_W-1:0] variant,
    output logic [PFX_W-1:0] code_q,
    output logic [2:0] len_q
);

    typedef struct packed {
        logic [PFX_W-1:0] code;
        logic [2:0] len;
    } rom_state_t;

    rom_state_t s_q;
    rom_state_t s_d;

    // Table of configuration prefixes
    always_comb begin
        s_d = '0;
        if (fs == FS_12K8) begin
            case (variant)
                3'h1: s_d = '{4'h1, 3'h1};
                3'h2: s_d = '{4'h5, 3'h4};
                3'h3: s_d = '{4'h4, 3'h4};
                3'h4: s_d = '{4'h3, 3'h3};
                3'h5: s_d = '{4'h1, 3'h3};
                3'h6: s_d = '{4'h1, 3'h4};
                3'h7: s_d = '{4'h0, 3'h4};
                default: s_d = '0;
            endcase
        end else begin
            case (variant)
                3'h1: s_d = '{4'h0, 3'h2};
                3'h2: s_d = '{4'h1, 3'h2};
                3'h3: s_d = '{4'h2, 3'h2};
                3'h4: s_d = '{4'h6, 3'h3};
                3'h5: s_d = '{4'h7, 3'h3};
                default: s_d = '0;
            endcase
        end
    end

    // Register the lookup
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign code_q = s_q.code;
    assign len_q = s_q.len;

endmodule

// ---- verilog/tc_frame_alloc.sv ----
`timescale 1ns/1ps
// What this block does
// - 12.8 kHz prefixes 1,0101,0100,011,001,0001,0000 for variants one to seven.
// - Variant one first subframe: 6-bit pitch, range above 34, below N.
// - Variant two: no pitch first; second 7-bit, min(N-k,34)..2N-1-k.
// - Variant two third and fourth subframes: 6-bit delta pitch.
// - Variant three second subframe: zero excitation, only 3-bit algebraic gain.
// - Variant three third subframe: 7-bit absolute, 2N-1-k to 3N-1-k.
// - Variant three fourth subframe: 5-bit delta pitch, as the 64K rate class is flagged invalid.
// - Variant four second, third subframes: zero excitation, 3-bit gain only.
// - Variant four fourth subframe: 7-bit pitch, 3N-k up to 231.
// - Variant five: first gain-only 3 bits; third 9-bit; fourth 5-bit delta.
// - Variant six: two algebraic-only subframes; third 5-bit, fourth 9-bit.
// - Variant seven: three algebraic-only; fourth 9-bit pitch, scalar gains.
// - 16 kHz prefixes 00,01,10,110,111; variant gives glottal-shape subframe.
// - 16 kHz variant one: 6-bit above 42, 8-bit below 2N, 10-bit, deltas.
// - 16 kHz adaptive or glottal subframes: 6-bit vector or 12-bit scalar gain.
// - 16 kHz variant two: first gain 3/6; 6, 10, 6 delta, 6 delta.
// - 16 kHz variant three: two algebraic-only; 10-bit then 6-bit deltas.
// - 16 kHz variant four: three algebraic-only; 10-bit then 6-bit delta.
// - 16 kHz variant five: pitch only fifth, 10-bit, scalar gain pair.
module tc_frame_alloc
    import tc_alloc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Request from the excitation search
    input wire logic req_valid,
    input wire alloc_req_t req,
    // Answer to the bitstream packer
    output logic ans_valid,
    output alloc_ans_t ans
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic v1;
        alloc_ans_t a1;
        logic v2;
        alloc_ans_t a2;
    } state_t;

    state_t s_q;
    state_t s_d;
    alloc_ans_t f;
    logic [PFX_W-1:0] pfx_code;
    logic [2:0] pfx_len;
    logic [9:0] n;
    logic [9:0] k;
    logic bad;
    logic hi;

    assign n = {2'h0, req.sf_len};
    assign k = {2'h0, req.imp_pos};
    assign hi = (req.rate == RATE_64K);

    // ------------------------------------------------------------------
    // Prefix lookup, registered in step with the field decode
    // ------------------------------------------------------------------
    tc_prefix_rom u_rom (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .fs(req.fs),
        .variant(req.variant),
        .code_q(pfx_code),
        .len_q(pfx_len)
    );

    // Range check of the request
    always_comb begin
        bad = 1'b0;
        if (req.fs == FS_12K8) begin
            bad = (req.variant == 3'h0) || (req.variant > NUM_VAR_12K8)
                || (req.subframe == 3'h0) || (req.subframe > NUM_SF_12K8)
                || hi;
        end else begin
            bad = (req.variant == 3'h0) || (req.variant > NUM_VAR_16K)
                || (req.subframe == 3'h0)
                || (req.subframe > NUM_SF_16K);
        end
    end

    // ------------------------------------------------------------------
    // Per-subframe field decode
    // ------------------------------------------------------------------
    always_comb begin
        f = '0;
        f.exc = EXC_ADA;
        f.gain = GAIN_VQ;
        f.gain_bits = W_VQ_GAIN;
        if (bad) begin
            f = '0;
            f.invalid = 1'b1;
        end else if (req.fs == FS_12K8) begin
            if (req.subframe == 3'h1 && req.variant <= 3'h4) begin
                f.exc = EXC_GS;
            end
            case (req.variant)
                3'h1: begin
                    if (req.subframe == 3'h1) begin
                        f.pit = PIT_ABS;
                        f.pit_bits = W_P6;
                        f.pit_min = PITCH_MIN_12K8 + 10'h1;
                        f.pit_max = n - 10'h1;
                    end else begin
                        f.pit = PIT_DELTA;
                        f.pit_bits = hi ? W_P6 : W_P5;
                    end
                end
                3'h2: begin
                    if (req.subframe == 3'h2) begin
                        f.pit = PIT_ABS;
                        f.pit_bits = W_P7;
                        f.pit_min = (n - k < PITCH_MIN_12K8) ? n - k
                            : PITCH_MIN_12K8;
                        f.pit_max = (n << 1) - 10'h1 - k;
                    end else if (req.subframe != 3'h1) begin
                        f.pit = PIT_DELTA;
                        f.pit_bits = W_P6;
                    end
                end
                3'h3: begin
                    case (req.subframe)
                        3'h2: begin
                            f.exc = EXC_ALG;
                            f.gain = GAIN_ALG;
                            f.gain_bits = W_ALG_GAIN;
                        end
                        3'h3: begin
                            f.pit = PIT_ABS;
                            f.pit_bits = W_P7;
                            f.pit_min = (n << 1) - 10'h1 - k;
                            f.pit_max = (n << 1) + n - 10'h1 - k;
                        end
                        3'h4: begin
                            f.pit = PIT_DELTA;
                            f.pit_bits = hi ? W_P6 : W_P5;
                        end
                        default: ;
                    endcase
                end
                3'h4: begin
                    if (req.subframe == 3'h2 || req.subframe == 3'h3) begin
                        f.exc = EXC_ALG;
                        f.gain = GAIN_ALG;
                        f.gain_bits = W_ALG_GAIN;
                    end else if (req.subframe == 3'h4) begin
                        f.pit = PIT_ABS;
                        f.pit_bits = W_P7;
                        f.pit_min = (n << 1) + n - k;
                        f.pit_max = PITCH_MAX_TC4;
                    end
                end
                3'h5: begin
                    case (req.subframe)
                        3'h1: begin
                            f.exc = EXC_ALG;
                            f.gain = GAIN_ALG;
                            f.gain_bits = W_ALG_GAIN;
                        end
                        3'h2: f.exc = EXC_GS;
                        3'h3: begin
                            f.pit = PIT_ABS;
                            f.pit_bits = W_P9;
                        end
                        3'h4: begin
                            f.pit = PIT_DELTA;
                            f.pit_bits = hi ? W_P6 : W_P5;
                        end
                        default: ;
                    endcase
                end
                3'h6: begin
                    case (req.subframe)
                        3'h1, 3'h2: begin
                            f.exc = EXC_ALG;
                            f.gain = GAIN_ALG;
                            f.gain_bits = W_ALG_GAIN;
                        end
                        3'h3: begin
                            f.exc = EXC_GS;
                            f.pit = PIT_ABS;
                            f.pit_bits = W_P5;
                        end
                        default: begin
                            f.pit = PIT_ABS;
                            f.pit_bits = W_P9;
                        end
                    endcase
                end
                default: begin
                    if (req.subframe != 3'h4) begin
                        f.exc = EXC_ALG;
                        f.gain = GAIN_ALG;
                        f.gain_bits = W_ALG_GAIN;
                    end else begin
                        f.exc = EXC_GS;
                        f.pit = PIT_ABS;
                        f.pit_bits = W_P9;
                        f.gain = GAIN_SQ;
                        f.gain_bits = W_SQ_GAIN;
                    end
                end
            endcase
        end else begin
            // Glottal-shape subframe equals the variant number
            if (req.subframe < req.variant) begin
                f.exc = EXC_ALG;
                f.gain = GAIN_ALG;
                f.gain_bits = hi ? W_ALG_GAIN_HI
                    : W_ALG_GAIN;
            end else begin
                f.exc = (req.subframe == req.variant) ? EXC_GS : EXC_ADA;
                f.gain = hi ? GAIN_SQ : GAIN_VQ;
                f.gain_bits = hi ? W_SQ_GAIN : W_VQ_GAIN;
                if (req.variant == 3'h5) begin
                    f.gain = GAIN_SQ;
                    f.gain_bits = W_SQ_GAIN;
                end
                f.pit = PIT_DELTA;
                f.pit_bits = W_P6;
                if (req.variant == 3'h1 && req.subframe == 3'h1) begin
                    f.pit = PIT_ABS;
                    f.pit_bits = W_P6;
                    f.pit_min = PITCH_MIN_16K + 10'h1;
                    f.pit_max = n - 10'h1;
                end else if (req.variant == 3'h1
                        && req.subframe == 3'h2) begin
                    f.pit = PIT_ABS;
                    f.pit_bits = W_P8;
                    f.pit_min = PITCH_MIN_16K + 10'h1;
                    f.pit_max = (n << 1) - 10'h1;
                end else if (req.variant == 3'h2
                        && req.subframe == 3'h2) begin
                    f.pit = PIT_ABS;
                    f.pit_bits = W_P6;
                end else if (req.subframe == 3'h3 && req.variant <= 3'h3) begin
                    f.pit = PIT_ABS;
                    f.pit_bits = W_P10;
                end else if (req.subframe == req.variant) begin
                    f.pit = PIT_ABS;
                    f.pit_bits = W_P10;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Two-stage pipeline; prefix joins at stage two
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.v1 = req_valid;
        s_d.a1 = f;
        s_d.v2 = s_q.v1;
        s_d.a2 = s_q.a1;
        if (!s_q.a1.invalid) begin
            s_d.a2.prefix = pfx_code;
            s_d.a2.prefix_len = pfx_len;
        end else begin
            s_d.a2.prefix = '0;
            s_d.a2.prefix_len = '0;
        end
    end

    // Register the state
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign ans_valid = s_q.v2;
    assign ans = s_q.a2;

endmodule

// ---- tb/tc_frame_alloc_checker.sv ----
`timescale 1ns/1ps
// Port checks on answer timing and allocation fields
module tc_frame_alloc_checker
    import tc_alloc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Request and answer
    input wire logic req_valid,
    input wire alloc_req_t req,
    input wire logic ans_valid,
    input wire alloc_ans_t ans
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    // Legal requests at each rate
    logic ok12;
    logic ok16;
    assign ok12 = req_valid && req.fs == FS_12K8 && req.rate == RATE_32K
        && req.subframe inside {[3'h1:3'h4]};
    assign ok16 = req_valid && req.fs == FS_16K
        && req.subframe inside {[3'h1:3'h5]};

    AST_LATENCY: assert property (req_valid |-> ##2 ans_valid)
        else $error("answer missing two cycles after request");
    AST_NO_EXTRA: assert property (ans_valid |-> $past(req_valid, 2))
        else $error("answer without request");
    AST_PFX_12K8: assert property (
        ok12 && req.variant == 3'h2 |->
        ##2 ans.prefix == 4'h5 && ans.prefix_len == 3'h4)
        else $error("wrong prefix at low rate");
    AST_PFX_16K: assert property (
        ok16 && req.variant == 3'h4 |->
        ##2 ans.prefix == 4'h6 && ans.prefix_len == 3'h3)
        else $error("wrong prefix at high rate");
    AST_TC3_ZERO: assert property (
        ok12 && req.variant == 3'h3 && req.subframe == 3'h2 |->
        ##2 ans.exc == EXC_ALG && ans.pit == PIT_NONE
        && ans.gain_bits == W_ALG_GAIN)
        else $error("zero excitation subframe fields wrong");
    AST_TC4_CEIL: assert property (
        ok12 && req.variant == 3'h4 && req.subframe == 3'h4 |->
        ##2 ans.pit_bits == W_P7 && ans.pit_max == PITCH_MAX_TC4)
        else $error("late pitch field wrong");
    AST_TC7_SCALAR: assert property (
        ok12 && req.variant == 3'h7 && req.subframe == 3'h4 |->
        ##2 ans.gain == GAIN_SQ && ans.pit_bits == W_P9)
        else $error("last subframe gain or pitch wrong");
    AST_16K_SQ: assert property (
        ok16 && req.rate == RATE_64K && req.variant inside {[3'h1:3'h5]}
        && req.subframe >= req.variant |-> ##2 ans.gain_bits == W_SQ_GAIN)
        else $error("high rate gain width wrong");
    AST_BAD_RATE: assert property (
        req_valid && req.fs == FS_12K8 && req.rate == RATE_64K |->
        ##2 ans.invalid)
        else $error("bad rate not flagged");
    AST_INV_ZERO: assert property (
        ans_valid && ans.invalid |-> ans.pit_bits == 4'h0
        && ans.gain_bits == 4'h0 && ans.prefix_len == 3'h0)
        else $error("flagged answer has nonzero widths");
endmodule

bind tc_frame_alloc tc_frame_alloc_checker chk_u (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .req_valid(req_valid),
    .req(req),
    .ans_valid(ans_valid),
    .ans(ans)
);

// ---- tb/tc_packer_model.sv ----
`timescale 1ns/1ps
// Bitstream packer side: takes each answer in its one valid cycle
module tc_packer_model
    import tc_alloc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Answer in
    input wire logic ans_valid,
    input wire alloc_ans_t ans,
    // Last answer taken and count
    output alloc_ans_t cap_q,
    output logic [15:0] cnt_q
);
    // Capture only on the pulse, the answer does not stand
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cap_q <= '0;
            cnt_q <= 16'h0;
        end else if (ans_valid) begin
            cap_q <= ans;
            cnt_q <= cnt_q + 16'h1;
        end
    end
endmodule

// ---- tb/tc_frame_alloc_test.sv ----
`timescale 1ns/1ps
module tc_frame_alloc_test
    import tc_alloc_pkg::*;
;
    localparam logic [3:0] PFX12 [0:7] = '{4'h0, 4'h1, 4'h5, 4'h4,
        4'h3, 4'h1, 4'h1, 4'h0};
    localparam logic [2:0] LEN12 [0:7] = '{3'h0, 3'h1, 3'h4, 3'h4,
        3'h3, 3'h3, 3'h4, 3'h4};
    localparam logic [3:0] PFX16 [0:7] = '{4'h0, 4'h0, 4'h1, 4'h2,
        4'h6, 4'h7, 4'h0, 4'h0};
    localparam logic [2:0] LEN16 [0:7] = '{3'h0, 3'h2, 3'h2, 3'h2,
        3'h3, 3'h3, 3'h0, 3'h0};
    logic sys_clk;
    logic arst_n;
    logic req_valid;
    alloc_req_t req;
    logic ans_valid;
    alloc_ans_t ans;
    alloc_ans_t cap;
    logic [15:0] n_seen;
    logic [15:0] n_prev;
    alloc_req_t req_q[$];
    int mismatches;
    int n_tests;
    int n_sent;
    int seed;

    // -----------------------------------------------------------------
    // Design, packer model and clock
    // -----------------------------------------------------------------
    tc_frame_alloc dut_u (.sys_clk(sys_clk), .arst_n(arst_n),
        .req_valid(req_valid), .req(req), .ans_valid(ans_valid), .ans(ans));
    tc_packer_model packer_u (.sys_clk(sys_clk), .arst_n(arst_n),
        .ans_valid(ans_valid), .ans(ans), .cap_q(cap), .cnt_q(n_seen));
    always #5 sys_clk = ~sys_clk;

    // -----------------------------------------------------------------
    // Expected answers
    // -----------------------------------------------------------------
    function automatic alloc_ans_t setp(alloc_ans_t a, pit_kind_t p,
        logic [3:0] w, logic [9:0] lo, logic [9:0] hi);
        a.pit = p;
        a.pit_bits = w;
        a.pit_min = lo;
        a.pit_max = hi;
        return a;
    endfunction

    // Width 4'hf marks a delta of 5 or 6 bits
    function automatic alloc_ans_t exp_ans(alloc_req_t r);
        alloc_ans_t a;
        logic [9:0] n;
        logic [9:0] k;
        int v;
        int s;
        int g;
        a = '0;
        n = 10'(r.sf_len);
        k = 10'(r.imp_pos);
        v = int'(r.variant);
        s = int'(r.subframe);
        a.invalid = 1'b1;
        if (r.fs == FS_12K8) begin
            if (v < 1 || v > 7 || s < 1 || s > 4 || r.rate == RATE_64K)
                return a;
            a.prefix = PFX12[v];
            a.prefix_len = LEN12[v];
            g = (v <= 4) ? 1 : v - 3;
        end else begin
            if (v < 1 || v > 5 || s < 1 || s > 5)
                return a;
            a.prefix = PFX16[v];
            a.prefix_len = LEN16[v];
            g = v;
        end
        a.invalid = 1'b0;
        a.exc = (s < g) ? EXC_ALG : (s == g) ? EXC_GS : EXC_ADA;
        if (r.fs == FS_12K8 && (v == 3 && s == 2 || v == 4 && s inside {2, 3}))
            a.exc = EXC_ALG;
        // Gains by excitation kind and rate class
        if (a.exc == EXC_ALG) begin
            a.gain = GAIN_ALG;
            a.gain_bits = (r.rate == RATE_64K) ? W_ALG_GAIN_HI : W_ALG_GAIN;
        end else if (r.rate == RATE_64K || v == 7 && s == 4 || v == 5 && s == 5) begin
            a.gain = GAIN_SQ;
            a.gain_bits = W_SQ_GAIN;
        end else begin
            a.gain = GAIN_VQ;
            a.gain_bits = W_VQ_GAIN;
        end
        // Pitch fields
        if (r.fs == FS_12K8) begin
            if (v == 1 && s == 1)
                a = setp(a, PIT_ABS, W_P6, 10'h023, n - 10'h1);
            else if (v == 2 && s == 2)
                a = setp(a, PIT_ABS, W_P7, (n - k < 10'h22) ? n - k : 10'h22,
                    n + n - 10'h1 - k);
            else if (v == 3 && s == 3)
                a = setp(a, PIT_ABS, W_P7, n + n - 10'h1 - k,
                    n + n + n - 10'h1 - k);
            else if (v == 4 && s == 4)
                a = setp(a, PIT_ABS, W_P7, n + n + n - k, 10'h0e7);
            else if (s == 4 && v > 5 || v == 5 && s == 3)
                a = setp(a, PIT_ABS, W_P9, '0, '0);
            else if (v == 6 && s == 3)
                a = setp(a, PIT_ABS, W_P5, '0, '0);
            else if (v == 2 && s > 2)
                a = setp(a, PIT_DELTA, W_P6, '0, '0);
            else if (a.exc == EXC_ADA)
                a = setp(a, PIT_DELTA, 4'hf, '0, '0);
        end else if (s == g)
            a = setp(a, PIT_ABS, (g < 3) ? W_P6 : W_P10,
                (g == 1) ? 10'h02b : '0, (g == 1) ? n - 10'h1 : '0);
        else if (g == 1 && s == 2)
            a = setp(a, PIT_ABS, W_P8, 10'h02b, n + n - 10'h1);
        else if (s > g)
            a = setp(a, s == 3 ? PIT_ABS : PIT_DELTA, s == 3 ? W_P10 : W_P6,
                '0, '0);
        return a;
    endfunction

    // -----------------------------------------------------------------
    // Compares, driver and verdict
    // -----------------------------------------------------------------
    task automatic cmp_ans(string what, alloc_ans_t e, alloc_ans_t got);
        n_tests++;
        if (got !== e) begin
            mismatches++;
            $display("BAD %s exp %h got %h", what, e, got);
        end
    endtask

    task automatic cmp_cnt(string what, logic [15:0] e, logic [15:0] got);
        n_tests++;
        if (got !== e) begin
            mismatches++;
            $display("BAD %s exp %h got %h", what, e, got);
        end
    endtask

    task automatic check_one(alloc_req_t r);
        alloc_ans_t e;
        e = exp_ans(r);
        // Delta width follows the rate class, never the design's answer
        if (e.pit_bits === 4'hf)
            e.pit_bits = (r.rate == RATE_64K) ? W_P6 : W_P5;
        cmp_cnt("prefix", {9'h0, e.prefix, e.prefix_len},
            {9'h0, cap.prefix, cap.prefix_len});
        if (e.invalid)
            cmp_ans("bad_combo", e, cap);
        else if (r.fs == FS_16K && r.variant < 3'h3)
            cmp_ans("hi_early", e, cap);
        else if (r.fs == FS_16K)
            cmp_ans("hi_late", e, cap);
        else if (r.variant < 3'h3)
            cmp_ans("lo_early", e, cap);
        else if (r.variant < 3'h5)
            cmp_ans("lo_mid", e, cap);
        else
            cmp_ans("lo_late", e, cap);
    endtask

    function automatic alloc_req_t mk_req(int f, int rt, int v, int s);
        alloc_req_t r;
        r.fs = fs_sel_t'(f[0]);
        r.rate = rate_class_t'(rt[0]);
        r.variant = 3'(v);
        r.subframe = 3'(s);
        r.sf_len = 8'(40 + $urandom % 200);
        r.imp_pos = 8'($urandom % r.sf_len);
        return r;
    endfunction

    task automatic drive(logic vld, alloc_req_t r);
        @(negedge sys_clk);
        req_valid = vld;
        req = r;
        if (vld) begin
            req_q.push_back(r);
            n_sent++;
        end
    endtask

    task automatic complete_run;
        if (mismatches == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Packer side: check each answer it takes, in order
    always @(negedge sys_clk) begin
        if (n_seen !== n_prev) begin
            n_prev = n_seen;
            if (req_q.size() == 0) begin
                mismatches++;
                $display("BAD answer exp none got %h", cap);
            end else
                check_one(req_q.pop_front());
        end
    end

    // Main sequence: full sweep back to back, then random traffic
    initial begin
        sys_clk = 1'b0;
        arst_n = 1'b0;
        req_valid = 1'b0;
        req = '0;
        n_prev = 16'h0;
        seed = $urandom(23192);
        repeat (16) @(posedge sys_clk);
        @(negedge sys_clk);
        arst_n = 1'b1;
        for (int c = 0; c < 32; c++)
            for (int s = 0; s < 6; s++)
                drive(1'b1, mk_req(c / 16, c / 8, c % 8, s));
        repeat (400)
            drive(1'($urandom), mk_req($urandom, $urandom, $urandom, $urandom));
        drive(1'b0, '0);
        repeat (4) @(negedge sys_clk);
        cmp_cnt("answers", 16'(n_sent), n_seen);
        complete_run;
    end

    // Watchdog
    initial begin
        repeat (5000) @(posedge sys_clk);
        mismatches++;
        complete_run;
    end
endmodule
